// ### common/pcc_pkg.sv
// package of constants and types for the pcm companding codec block
package pcc_pkg;

    // ------------------------------------------------------------------
    // register map (index = printed register number, byte address = 4 x index)
    // ------------------------------------------------------------------
    localparam logic [5:0] PCC_IDX_FMT   = 6'h04;   // interface format
    localparam logic [5:0] PCC_IDX_CMP   = 6'h05;   // companding control
    localparam logic [5:0] PCC_IDX_STAT  = 6'h06;   // last bytes and busy

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned PCC_WLS_LSB   = 5;      // word_length_select bits 6:5
    localparam int unsigned PCC_OVR_BIT   = 5;      // eight_bit_override
    localparam int unsigned PCC_DACEN_BIT = 4;
    localparam int unsigned PCC_DACAL_BIT = 3;
    localparam int unsigned PCC_ADCEN_BIT = 2;
    localparam int unsigned PCC_ADCAL_BIT = 1;
    localparam int unsigned PCC_BUSY_BIT  = 16;     // status: frame in progress

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  PCC_WLS_RST   = 2'h0;
    localparam logic [4:0]  PCC_CMP_RST   = 5'h00;  // no companding

    // ------------------------------------------------------------------
    // word lengths in bits
    // ------------------------------------------------------------------
    localparam logic [5:0]  PCC_WL_8      = 6'h08;
    localparam logic [5:0]  PCC_WL_16     = 6'h10;
    localparam logic [5:0]  PCC_WL_20     = 6'h14;
    localparam logic [5:0]  PCC_WL_24     = 6'h18;
    localparam logic [5:0]  PCC_WL_32     = 6'h20;

    // ------------------------------------------------------------------
    // companding constants
    // ------------------------------------------------------------------
    localparam logic [15:0] PCC_MU_BIAS   = 16'h0084;
    localparam logic [15:0] PCC_MU_CLIP   = 16'h7F7B;
    localparam logic [15:0] PCC_MAG_MAX   = 16'h7FFF;
    localparam logic [15:0] PCC_AL_ROUND  = 16'h0008;
    localparam logic [15:0] PCC_AL_SEG    = 16'h0100;
    localparam logic [7:0]  PCC_AL_XOR    = 8'h55;

    // companding control, carried as one unit
    typedef struct packed {
        logic eight_bit_override;
        logic dac_en;
        logic dac_alaw;
        logic adc_en;
        logic adc_alaw;
    } pcc_ctrl_t;

    // serial link frame state
    typedef enum logic [0:0] {
        PCC_IDLE  = 1'b0,
        PCC_SHIFT = 1'b1
    } pcc_state_t;

endpackage : pcc_pkg

// ### hw/pcc_codec.sv
// pcm serial port with a-law / mu-law compression and expansion, apb registers
`timescale 1ns/100ps
// Behaviour
// - a-law and mu-law, separately per direction
// - compress linear samples to 8 bits, expand back
// - byte is sign, 3-bit exponent, 4-bit mantissa
// - mu-law segment curve, mu 255
// - a-law linear then log, A 87.6
// - override bit forces 8-bit serial words
// - override ignores word length select field
// - control bits 4..1 enable and choose law
module pcc_codec (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                link_bclk,
    input  wire logic                link_frame,
    input  wire logic                link_rx_data,
    output logic                     link_tx_data,
    output logic                     link_tx_oe,
    input  wire logic [15:0]         adc_sample,
    output logic      [15:0]         dac_sample,
    output logic                     dac_valid
);
    import pcc_pkg::*;

    // ------------------------------------------------------------------
    // companding functions
    // ------------------------------------------------------------------
    function automatic logic [7:0] mu_compress(input logic [15:0] s);
        logic        sgn;
        logic [15:0] mag;
        logic [2:0]  e;
        sgn = s[15];
        mag = sgn ? 16'(-s) : s;
        if (mag > PCC_MU_CLIP) begin
            mag = PCC_MU_CLIP;
        end
        mag = 16'(mag + PCC_MU_BIAS);
        e = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (mag[i + 7]) begin
                e = 3'(i);
            end
        end
        // shift widened to four bits: exponents 5..7 would wrap a 3-bit sum
        mu_compress = ~{sgn, e, 4'(mag >> (4'(e) + 4'h3))};
    endfunction : mu_compress

    function automatic logic [7:0] a_compress(input logic [15:0] s);
        logic        sgn;
        logic [15:0] mag;
        logic [11:0] m12;
        logic [2:0]  e;
        sgn = s[15];
        // ones' complement keeps negative steps aligned with the 13-bit grid
        mag = sgn ? ~s : s;
        if (mag > PCC_MAG_MAX) begin
            mag = PCC_MAG_MAX;
        end
        m12 = mag[14:3];                                    // 12-bit magnitude
        e = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (m12[i + 4]) begin
                e = 3'(i);
            end
        end
        // segment 0 is the linear part, same step as segment 1
        a_compress = {~sgn, e, (e == 3'h0) ? m12[4:1] : 4'(m12 >> e)} ^ PCC_AL_XOR;
    endfunction : a_compress

    function automatic logic [15:0] mu_expand(input logic [7:0] c);
        logic [7:0]  u;
        logic [15:0] t;
        u = ~c;
        t = 16'((16'({u[3:0], 3'b000}) + PCC_MU_BIAS) << u[6:4]);
        mu_expand = u[7] ? 16'(PCC_MU_BIAS - t) : 16'(t - PCC_MU_BIAS);
    endfunction : mu_expand

    function automatic logic [15:0] a_expand(input logic [7:0] c);
        logic [7:0]  a;
        logic [15:0] t;
        a = c ^ PCC_AL_XOR;
        t = 16'(16'({a[3:0], 4'b0000}) + PCC_AL_ROUND);
        if (a[6:4] != 3'h0) begin
            t = 16'((t + PCC_AL_SEG) << (a[6:4] - 3'h1));
        end
        a_expand = a[7] ? t : 16'(-t);
    endfunction : a_expand

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    pcc_ctrl_t   ctrl_q;
    logic [1:0]  wls_q;
    logic [31:0] prdata_q;
    pcc_state_t  state_q;
    logic [5:0]  cnt_q;
    logic [31:0] tx_sh_q;
    logic [31:0] rx_sh_q;
    logic        tx_data_q;
    logic        tx_oe_q;
    logic [15:0] dac_q;
    logic        dac_valid_q;
    logic [7:0]  last_tx_q;
    logic [7:0]  last_rx_q;
    logic [2:0]  sync_q [3];
    logic        bclk_rise;
    logic        bclk_fall;
    logic        frame_s;
    logic        rx_s;
    logic [5:0]  word_length_select;
    logic [31:0] rx_next;
    logic [31:0] rx_aligned;
    logic [7:0]  tx_byte;
    logic        setup;
    logic        access;
    logic        hit;

    // ------------------------------------------------------------------
    // apb slave: zero wait states, read data captured in the setup cycle
    // ------------------------------------------------------------------
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign hit     = (paddr[7:2] == PCC_IDX_FMT) | (paddr[7:2] == PCC_IDX_CMP) | (paddr[7:2] == PCC_IDX_STAT);
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;
    assign prdata  = prdata_q;

    // control registers written at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= pcc_ctrl_t'(PCC_CMP_RST);
            wls_q  <= PCC_WLS_RST;
        end else if (access && pwrite && paddr[7:2] == PCC_IDX_CMP) begin
            ctrl_q <= '{pwdata[PCC_OVR_BIT], pwdata[PCC_DACEN_BIT], pwdata[PCC_DACAL_BIT],
                        pwdata[PCC_ADCEN_BIT], pwdata[PCC_ADCAL_BIT]};
        end else if (access && pwrite && paddr[7:2] == PCC_IDX_FMT) begin
            wls_q  <= pwdata[PCC_WLS_LSB +: 2];
        end
    end

    // read mux; unmapped addresses read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            prdata_q <= 32'h00000000;
            case (paddr[7:2])
                PCC_IDX_FMT:  prdata_q[PCC_WLS_LSB +: 2] <= wls_q;
                PCC_IDX_CMP:  prdata_q[PCC_OVR_BIT:PCC_ADCAL_BIT] <= ctrl_q;
                PCC_IDX_STAT: prdata_q[PCC_BUSY_BIT:0] <= {state_q == PCC_SHIFT, last_rx_q, last_tx_q};
                default:      prdata_q <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // link pin synchronisers: stage 0 feeds only stage 1
    // ------------------------------------------------------------------
    logic [2:0] pins_in;
    assign pins_in = {link_bclk, link_frame, link_rx_data};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync_q[g] <= 3'h0;
            end else begin
                sync_q[g] <= {sync_q[g][1:0], pins_in[g]};
            end
        end
    end

    // bclk edges found from stages 1 and 2; frame and data read at stage 1
    assign bclk_rise = sync_q[2][1] & ~sync_q[2][2];
    assign bclk_fall = ~sync_q[2][1] & sync_q[2][2];
    assign frame_s   = sync_q[1][1];
    assign rx_s      = sync_q[0][1];

    // override wins over the word length field
    always_comb begin
        if (ctrl_q.eight_bit_override) begin
            word_length_select = PCC_WL_8;
        end else begin
            case (wls_q)
                2'h0:    word_length_select = PCC_WL_16;
                2'h1:    word_length_select = PCC_WL_20;
                2'h2:    word_length_select = PCC_WL_24;
                default: word_length_select = PCC_WL_32;
            endcase
        end
    end

    // compressed byte for transmit, law per adc select
    assign tx_byte    = ctrl_q.adc_alaw ? a_compress(adc_sample) : mu_compress(adc_sample);
    assign rx_next    = {rx_sh_q[30:0], rx_s};
    assign rx_aligned = rx_next << (6'(PCC_WL_32 - word_length_select));  // word msb to bit 31

    // ------------------------------------------------------------------
    // frame engine: start on a bclk rise with frame high, drive on fall,
    // sample on rise; word_length_select is read live, so change it only between frames
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= PCC_IDLE;
            cnt_q     <= 6'h00;
            tx_sh_q   <= 32'h00000000;
            rx_sh_q   <= 32'h00000000;
            tx_data_q <= 1'b0;
            tx_oe_q   <= 1'b0;
            last_tx_q <= 8'h00;
        end else begin
            case (state_q)
                PCC_IDLE: begin
                    if (bclk_rise && frame_s) begin
                        state_q <= PCC_SHIFT;
                        cnt_q   <= word_length_select;
                        rx_sh_q <= 32'h00000000;
                        tx_oe_q <= 1'b1;
                        last_tx_q <= tx_byte;
                        // compress just before serialising
                        tx_sh_q <= ctrl_q.adc_en ? {tx_byte, 24'h000000} : {adc_sample, 16'h0000};
                    end
                end
                PCC_SHIFT: begin
                    if (bclk_fall) begin
                        tx_data_q <= tx_sh_q[31];
                        tx_sh_q   <= {tx_sh_q[30:0], 1'b0};
                    end
                    if (bclk_rise) begin
                        rx_sh_q <= rx_next;
                        cnt_q   <= 6'(cnt_q - 6'h01);
                        if (cnt_q == 6'h01) begin
                            state_q <= PCC_IDLE;
                            tx_oe_q <= 1'b0;
                        end
                    end
                end
                default: state_q <= PCC_IDLE;
            endcase
        end
    end

    // received word delivered on the last sampling edge, expanded if enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_q       <= 16'h0000;
            dac_valid_q <= 1'b0;
            last_rx_q   <= 8'h00;
        end else begin
            dac_valid_q <= 1'b0;
            if (state_q == PCC_SHIFT && bclk_rise && cnt_q == 6'h01) begin
                dac_valid_q <= 1'b1;
                last_rx_q   <= rx_aligned[31:24];
                if (ctrl_q.dac_en) begin
                    dac_q <= ctrl_q.dac_alaw ? a_expand(rx_aligned[31:24])
                                             : mu_expand(rx_aligned[31:24]);
                end else begin
                    dac_q <= rx_aligned[31:16];
                end
            end
        end
    end

    assign link_tx_data = tx_data_q;
    assign link_tx_oe   = tx_oe_q;
    assign dac_sample   = dac_q;
    assign dac_valid    = dac_valid_q;

endmodule : pcc_codec

// ### tb/pcc_codec_props.sv
// port checker for the companding codec, bound to the design
`timescale 1ns/100ps
module pcc_codec_props
    import pcc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        link_frame,
    input wire logic        link_tx_oe,
    input wire logic [15:0] dac_sample,
    input wire logic        dac_valid
);
    logic acc;
    logic unm;
    // access phase, and whether it misses every mapped word
    assign acc = psel && penable;
    assign unm = !(paddr[7:2] inside {PCC_IDX_FMT, PCC_IDX_CMP, PCC_IDX_STAT});
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // zero wait states, error only on unmapped words
    pready_high_a: assert property (pready) else $error("pready low");
    unmap_err_a: assert property (acc && unm |-> pslverr) else $error("no error");
    map_ok_a: assert property (acc && !unm |-> !pslverr) else $error("bad error");
    idle_err_a: assert property (!acc |-> !pslverr) else $error("stray error");
    unmap_zero_a: assert property (acc && unm && !pwrite |-> prdata == 32'h0) else $error("unmapped data");
    // received words come out as single pulses after the frame
    valid_pulse_a: assert property (dac_valid |=> !dac_valid) else $error("long valid");
    dac_hold_a: assert property ($changed(dac_sample) |-> dac_valid) else $error("dac moved");
    valid_idle_a: assert property (dac_valid |-> !link_tx_oe) else $error("valid in frame");
    // a frame only opens under frame sync
    oe_frame_a: assert property ($rose(link_tx_oe) |-> link_frame) else $error("oe without sync");
endmodule : pcc_codec_props
bind pcc_codec pcc_codec_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_frame(link_frame), .link_tx_oe(link_tx_oe),
    .dac_sample(dac_sample), .dac_valid(dac_valid)
);

// ### tb/pcc_host_model.sv
// behavioural host on the pcm link: bit clock, frame sync, both data lines
`timescale 1ns/100ps
module pcc_host_model (
    output logic      link_bclk,
    output logic      link_frame,
    output logic      link_rx_data,
    input  wire logic link_tx_data,
    input  wire logic link_tx_oe
);
    localparam time HALF = 24; // 48 ns bit clock
    initial begin
        link_bclk = 1'b0;
        link_frame = 1'b0;
        link_rx_data = 1'b1;
    end
    // one frame of n bits, msb first; the clock stands low between frames
    task automatic xfer(input int n, input logic [31:0] rx, output logic [31:0] tx);
        tx = 32'h0;
        // pins move by non-blocking assignment: their edges land on pclk edges
        link_frame <= 1'b1;
        #HALF link_bclk <= 1'b1;
        for (int i = 0; i < n; i++) begin
            #HALF link_bclk <= 1'b0;
            link_frame <= 1'b0;
            link_rx_data <= rx[31-i];
            #HALF link_bclk <= 1'b1;
            tx[31-i] = link_tx_oe ? link_tx_data : 1'bx;
        end
        #HALF link_bclk <= 1'b0;
        // released line shows the inverse so a stale bit cannot pass
        link_rx_data <= ~link_rx_data;
    endtask : xfer
endmodule : pcc_host_model

// ### tb/pcc_codec_bench.sv
// self-checking bench for the pcm companding codec
`timescale 1ns/100ps
module pcc_codec_bench;
    import pcc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, txw;
    logic        link_bclk, link_frame, link_rx_data, link_tx_data, link_tx_oe;
    logic [15:0] adc_sample, dac_sample, last_dac;
    logic        dac_valid;
    int          n_fail = 0;
    int          num_checks = 0;
    pcc_codec u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_bclk(link_bclk),
        .link_frame(link_frame), .link_rx_data(link_rx_data),
        .link_tx_data(link_tx_data), .link_tx_oe(link_tx_oe),
        .adc_sample(adc_sample), .dac_sample(dac_sample), .dac_valid(dac_valid)
    );
    pcc_host_model u_host (
        .link_bclk(link_bclk), .link_frame(link_frame), .link_rx_data(link_rx_data),
        .link_tx_data(link_tx_data), .link_tx_oe(link_tx_oe)
    );
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // keep the last received word so late pulses are not missed
    always @(posedge pclk) begin
        if (dac_valid === 1'b1) last_dac <= dac_sample;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one link frame; only the first n bits of the word are compared
    task automatic frm(input int n, input logic [31:0] rx, input logic [31:0] etx,
                       input logic [15:0] edac, input bit cd);
        logic [31:0] m;
        m = ~(32'hFFFFFFFF >> n);
        last_dac = 16'hxxxx;
        u_host.xfer(n, rx, txw);
        repeat (4) @(posedge pclk);
        chk("tx word", txw & m, etx & m);
        chk("frame closed", link_tx_oe, 1'b0);
        if (cd) chk("dac word", last_dac, edac);
    endtask : frm
    function automatic logic [7:0] mu_enc(input logic [15:0] s);
        int v, e;
        v = $signed(s);
        if (v < 0) v = -v;
        if (v > 32635) v = 32635;
        v = v + 132;
        e = 7;
        while (e > 0 && v[e+7] == 1'b0) e--;
        return ~{s[15], e[2:0], v[e+3 +: 4]};
    endfunction : mu_enc
    function automatic logic [7:0] al_enc(input logic [15:0] s);
        int v, g;
        logic [7:0] m;
        v = $signed(s) >>> 3;
        m = (v >= 0) ? 8'hD5 : 8'h55;
        if (v < 0) v = -v - 1;
        g = 0;
        while (g < 7 && v > (32 << g) - 1) g++;
        return {1'b0, g[2:0], (g < 2) ? v[4:1] : v[g +: 4]} ^ m;
    endfunction : al_enc
    function automatic logic [15:0] al_dec(input logic [7:0] b);
        logic [7:0] a;
        int t, g;
        a = b ^ 8'h55;
        g = a[6:4];
        t = (a[3:0] << 4) + ((g == 0) ? 8 : 264);
        if (g > 1) t = t << (g - 1);
        return 16'(a[7] ? t : -t);
    endfunction : al_dec
    function automatic logic [15:0] mu_dec(input logic [7:0] b);
        logic [7:0] u;
        int t;
        u = ~b;
        t = ((u[3:0] << 3) + 132) << u[6:4];
        return 16'(u[7] ? 132 - t : t - 132);
    endfunction : mu_dec
    // hang guard, far beyond the few dozen frames below
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial begin
        logic [31:0] rxw;
        logic [15:0] s;
        logic [7:0]  b, e;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        adc_sample = 16'h0000;
        presetn = 1'b0;
        void'($urandom(93));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        // reset values, reserved bits, unmapped word
        apb(1'b0, 8'h10, 32'h0);
        chk("format reset", rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("control reset", rd, 32'h0);
        apb(1'b1, 8'h14, 32'hFFFFFFFF);
        apb(1'b0, 8'h14, 32'h0);
        chk("control bits", rd, 32'h3E);
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        chk("unmapped error", err, 1'b1);
        // linear words at each length, then the override at each length
        for (int o = 0; o < 2; o++) begin
            apb(1'b1, 8'h14, o ? 32'h20 : 32'h0);
            for (int w = 0; w < 4; w++) begin
                apb(1'b1, 8'h10, 32'(w) << 5);
                apb(1'b0, 8'h10, 32'h0);
                chk("format field", rd, 32'(w) << 5);
                adc_sample <= 16'($urandom);
                rxw = $urandom;
                @(posedge pclk);
                frm(o ? 8 : (w == 3 ? 32 : 16 + 4 * w), rxw, {adc_sample, 16'h0}, rxw[31:16], !o);
            end
        end
        // both directions companded, laws crossed; override keeps 8-bit words
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h14, 32'h34 | (32'(k & 1) << 3) | (32'(k >> 1) << 1));
            for (int j = 0; j < 6; j++) begin
                s = (j == 0) ? 16'h7FFF : (j == 1) ? 16'h8001 : (j == 2) ? 16'h0000 : 16'($urandom) | 16'h0001;
                b = 8'($urandom);
                adc_sample <= s;
                @(posedge pclk);
                e = (k >> 1) ? al_enc(s) : mu_enc(s);
                frm(8, {b, 24'h0}, {e, 24'h0}, (k & 1) ? al_dec(b) : mu_dec(b), 1'b1);
            end
            apb(1'b0, 8'h18, 32'h0);
            chk("last sent byte", rd[7:0], e);
            chk("last recv byte", rd[15:8], b);
            chk("frame busy", rd[16], 1'b0);
        end
        finish_test();
    end
endmodule : pcc_codec_bench
